// ==== common/occ_pkg.sv ====
// Package for the output compare and PWM channel: map, fields, mode codes.
package occ_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] OFS_SECONDARY = 16'h0180;
  localparam logic [15:0] OFS_PRIMARY = 16'h0182;
  localparam logic [15:0] OFS_CONTROL = 16'h0184;
  localparam logic [15:0] OFS_STATUS = 16'h0190;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTL_IDLE_STOP_POS = 13;
  localparam int CTL_FAULT_POS = 4;
  localparam int CTL_TSEL_POS = 3;
  localparam int STS_IRQ_POS = 0;
  localparam int STS_PIN_POS = 1;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // ****************************************************************
  // Compare mode codes
  // ****************************************************************
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_LOW = 3'h1;
  localparam logic [2:0] MODE_HIGH = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_SINGLE = 3'h4;
  localparam logic [2:0] MODE_CONT = 3'h5;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;

  // ****************************************************************
  // Time base view from one timer
  // ****************************************************************
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic step;
    logic run;
    logic idle_stop;
  } occ_timer_t;

endpackage

// ==== core/occ_channel.sv ====
// Output compare channel with simple match, dual pulse and buffered PWM.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1 - Time base is timer A or B, chosen by control bit 3, A by default.
// RULE2 - Mode codes 001, 010 and 011 are simple match modes.
// RULE3 - Simple modes match primary value to selected count, then act.
// RULE4 - A timer wrap without reaching the primary value leaves the pin alone.
// RULE5 - Codes 100 and 101 are single and continuous dual compare pulse modes.
// RULE6 - After a single pulse, only rewriting mode 100 gives another pulse.
// RULE7 - Software loads values with timer stopped, writes mode 100, then runs.
// RULE8 - Software loads values, writes mode 101, then starts the timer.
// RULE9 - Codes 110, 111 are PWM; secondary buffers duty, primary read-only.
// RULE10 - Software writes period, duty, PWM mode, then starts the timer.
// RULE11 - In mode 111 a low fault input releases the pin, sets fault flag.
// RULE12 - Fault state holds until input is high and mode is rewritten to PWM.
// RULE13 - PWM period is period value plus one, times four, times prescale.
// RULE14 - On wrap after period the pin is set and secondary copies to primary.
// RULE15 - In PWM a zero duty keeps the pin low at each period start.
// RULE16 - In PWM a duty above the period keeps the pin high continuously.
// RULE17 - Outside PWM a compare event sets the sticky compare interrupt flag.
// RULE18 - In PWM the compare interrupt flag is never set.
// RULE19 - In sleep the pin holds its level, operation resumes on wake-up.
// RULE20 - Idle runs only with both idle stop bits clear and timer on.
// RULE21 - Code 001 drives low, 010 drives high, 011 inverts the pin on match.
// RULE22 - Pulse modes: high on primary match, low on secondary; 101 repeats.
module occ_channel (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire occ_pkg::occ_timer_t timer_a,
  input wire occ_pkg::occ_timer_t timer_b,
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  input wire logic fault_input_pin_n,
  output logic compare_output_pin,
  output logic compare_output_pin_oe_n,
  output logic compare_irq_flag
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == occ_pkg::MODE_PWM) || (m == occ_pkg::MODE_PWM_FAULT);
  endfunction

  function automatic logic is_simple(input logic [2:0] m);
    is_simple = (m == occ_pkg::MODE_LOW) || (m == occ_pkg::MODE_HIGH) ||
                (m == occ_pkg::MODE_TOGGLE);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [15:0] ZERO16 = occ_pkg::ZERO_WORD;

  logic [15:0] primary_compare_value;
  logic [15:0] secondary_compare_value;
  logic [2:0] compare_mode_field;
  logic time_base_select;
  logic idle_stop_bit;
  logic fault_flag;
  logic pulse_done;
  logic fault_meta;
  logic fault_sync_n;
  occ_pkg::occ_timer_t tmr;
  logic run;
  logic wr_ctrl;
  logic match_primary;
  logic match_secondary;
  logic wrap;
  logic fault_now;

  // ****************************************************************
  // Time base selection and run gating
  // ****************************************************************
  always_comb begin
    tmr = time_base_select ? timer_b : timer_a; // [RULE1]
  end

  // Sleep freezes the pin, its enable and all compare events; idle keeps it running only
  // when both idle stop bits are clear and the timer is on.
  assign run = !cpu_sleep && // [RULE19]
               !(cpu_idle && (idle_stop_bit || !tmr.run ||
                 tmr.idle_stop)); // [RULE20]

  assign wr_ctrl = reg_wr && (reg_addr == occ_pkg::OFS_CONTROL);
  assign match_primary = run && tmr.step &&
                         (tmr.count == primary_compare_value); // [RULE3]
  assign match_secondary = run && tmr.step &&
                           (tmr.count == secondary_compare_value);
  // The timer clears itself one step after it equals its period, so a
  // fresh zero count on a step marks the start of a new period.
  assign wrap = run && tmr.step && (tmr.count == ZERO16); // [RULE13] [RULE14]
  assign fault_now = (compare_mode_field == occ_pkg::MODE_PWM_FAULT) &&
                     !fault_sync_n;

  // ****************************************************************
  // Fault input synchroniser
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_meta <= 1'b1;
      fault_sync_n <= 1'b1;
    end else begin
      fault_meta <= fault_input_pin_n;
      fault_sync_n <= fault_meta;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_mode_field <= occ_pkg::MODE_OFF;
      time_base_select <= 1'b0;
      idle_stop_bit <= 1'b0;
    end else if (wr_ctrl) begin
      compare_mode_field <= reg_wdata[2:0]; // [RULE2] [RULE5] [RULE9]
      time_base_select <= reg_wdata[occ_pkg::CTL_TSEL_POS];
      idle_stop_bit <= reg_wdata[occ_pkg::CTL_IDLE_STOP_POS];
    end
  end

  // A fault seen in the same cycle as the re-enabling write wins.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_flag <= 1'b0;
    end else if (run && fault_now) begin
      fault_flag <= 1'b1; // [RULE11]
    end else if (wr_ctrl && is_pwm(reg_wdata[2:0]) && fault_sync_n) begin
      fault_flag <= 1'b0; // [RULE12]
    end
  end

  // ****************************************************************
  // Compare values
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      secondary_compare_value <= occ_pkg::RST_COMPARE;
    end else if (reg_wr && reg_addr == occ_pkg::OFS_SECONDARY) begin
      secondary_compare_value <= reg_wdata;
    end
  end

  // In PWM the primary value is the active duty latch; software writes
  // are dropped so that a duty change can only land at a period boundary.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      primary_compare_value <= occ_pkg::RST_COMPARE;
    end else if (is_pwm(compare_mode_field)) begin
      if (wrap) begin
        primary_compare_value <= secondary_compare_value; // [RULE9] [RULE14]
      end
    end else if (reg_wr && reg_addr == occ_pkg::OFS_PRIMARY) begin
      primary_compare_value <= reg_wdata;
    end
  end

  // ****************************************************************
  // Single pulse bookkeeping
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pulse_done <= 1'b0;
    end else if (wr_ctrl) begin
      pulse_done <= 1'b0; // [RULE6]
    end else if (compare_mode_field == occ_pkg::MODE_SINGLE &&
                 match_secondary && compare_output_pin) begin
      pulse_done <= 1'b1; // [RULE6]
    end
  end

  // ****************************************************************
  // Output pin
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_output_pin <= 1'b0;
    end else if (run) begin
      unique case (compare_mode_field)
        occ_pkg::MODE_OFF: begin
          compare_output_pin <= 1'b0;
        end
        occ_pkg::MODE_LOW: begin
          if (match_primary) begin
            compare_output_pin <= 1'b0; // [RULE21]
          end
        end
        occ_pkg::MODE_HIGH: begin
          if (match_primary) begin
            compare_output_pin <= 1'b1; // [RULE21]
          end
        end
        occ_pkg::MODE_TOGGLE: begin
          // A wrap short of the primary value is no match. [RULE4]
          if (match_primary) begin
            compare_output_pin <= !compare_output_pin; // [RULE21]
          end
        end
        occ_pkg::MODE_SINGLE, occ_pkg::MODE_CONT: begin
          if (compare_mode_field == occ_pkg::MODE_SINGLE && pulse_done) begin
            compare_output_pin <= 1'b0; // [RULE6]
          end else if (match_primary) begin
            compare_output_pin <= 1'b1; // [RULE22]
          end else if (match_secondary) begin
            compare_output_pin <= 1'b0; // [RULE22]
          end
        end
        occ_pkg::MODE_PWM, occ_pkg::MODE_PWM_FAULT: begin
          // A duty above the period never matches, so the pin stays high.
          if (wrap) begin
            compare_output_pin <= |secondary_compare_value; // [RULE15]
          end else if (match_primary) begin
            compare_output_pin <= 1'b0; // [RULE16]
          end
        end
      endcase
    end
  end

  // Pin released in mode 000 and, in mode 111, while a fault stands.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_output_pin_oe_n <= 1'b1;
    end else if (run) begin
      compare_output_pin_oe_n <= (compare_mode_field == occ_pkg::MODE_OFF) ||
        (compare_mode_field == occ_pkg::MODE_PWM_FAULT &&
         (fault_flag || !fault_sync_n)); // [RULE11] [RULE12]
    end
  end

  // ****************************************************************
  // Compare interrupt flag
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_irq_flag <= 1'b0;
    end else if ((is_simple(compare_mode_field) && match_primary) ||
                 (compare_mode_field == occ_pkg::MODE_CONT &&
                  (match_primary || match_secondary)) ||
                 (compare_mode_field == occ_pkg::MODE_SINGLE &&
                  !pulse_done && (match_primary || match_secondary))) begin
      compare_irq_flag <= 1'b1; // [RULE17] [RULE18]
    end else if (reg_wr && reg_addr == occ_pkg::OFS_STATUS &&
                 reg_wdata[occ_pkg::STS_IRQ_POS]) begin
      compare_irq_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= ZERO16;
    end else if (reg_rd) begin
      unique case (reg_addr)
        occ_pkg::OFS_SECONDARY: reg_rdata <= secondary_compare_value;
        occ_pkg::OFS_PRIMARY: reg_rdata <= primary_compare_value;
        occ_pkg::OFS_CONTROL: begin
          reg_rdata <= {2'h0, idle_stop_bit, 8'h00, fault_flag,
                        time_base_select, compare_mode_field};
        end
        occ_pkg::OFS_STATUS: begin
          reg_rdata <= {14'h0000, compare_output_pin, compare_irq_flag};
        end
        default: reg_rdata <= ZERO16;
      endcase
    end else begin
      reg_rdata <= ZERO16;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking occ_cb @(posedge clk_sys);
  endclocking

  default disable iff (reset);

  sequence s_single_spent;
    compare_mode_field == occ_pkg::MODE_SINGLE && pulse_done && !wr_ctrl;
  endsequence

  sequence s_pwm_wrap;
    is_pwm(compare_mode_field) && wrap && !wr_ctrl;
  endsequence

  // With timer B selected, a step of timer A alone must never move a simple-mode pin.
  AST_TSEL_B: assert property ( // [RULE1]
    time_base_select && is_simple(compare_mode_field) && !wr_ctrl &&
    !timer_b.step |=> $stable(compare_output_pin)
  ) else $error("Time base does not follow the select bit.");

  AST_MATCH_LOW: assert property ( // [RULE21]
    compare_mode_field == occ_pkg::MODE_LOW && match_primary && !wr_ctrl
    |=> !compare_output_pin
  ) else $error("Low match did not drive the pin low.");

  AST_MATCH_TOGGLE: assert property ( // [RULE3]
    compare_mode_field == occ_pkg::MODE_TOGGLE && match_primary && !wr_ctrl
    |=> compare_output_pin != $past(compare_output_pin)
  ) else $error("Toggle match did not invert the pin.");

  AST_WRAP_HOLD: assert property ( // [RULE4]
    is_simple(compare_mode_field) && !match_primary && !wr_ctrl
    |=> $stable(compare_output_pin)
  ) else $error("Simple mode pin moved without a match.");

  // The flag is sticky from the pulse itself, so only a new rise counts.
  AST_SINGLE_ONCE: assert property ( // [RULE6]
    s_single_spent |=> !compare_output_pin && !$rose(compare_irq_flag)
  ) else $error("Spent single pulse produced output.");

  AST_PWM_LATCH: assert property ( // [RULE14]
    s_pwm_wrap |=> primary_compare_value == $past(secondary_compare_value) &&
    compare_output_pin == ($past(secondary_compare_value) != ZERO16)
  ) else $error("Period start did not latch duty and set the pin.");

  // A zero duty latched at the boundary may legally pull the pin low.
  AST_PWM_HIGH: assert property ( // [RULE16]
    is_pwm(compare_mode_field) && !wr_ctrl && compare_output_pin &&
    primary_compare_value > tmr.period && tmr.count <= tmr.period &&
    !(wrap && secondary_compare_value == ZERO16)
    |=> compare_output_pin
  ) else $error("Duty above period let the pin fall.");

  AST_FAULT_TRI: assert property ( // [RULE11]
    run && fault_now && !wr_ctrl |=> fault_flag ##1 compare_output_pin_oe_n
  ) else $error("Fault did not release the pin and flag it.");

  AST_FAULT_HOLD: assert property ( // [RULE12]
    fault_flag && !wr_ctrl |=> fault_flag
  ) else $error("Fault flag cleared without a mode rewrite.");

  AST_PWM_NO_IRQ: assert property ( // [RULE18]
    is_pwm(compare_mode_field) && !compare_irq_flag |=> !compare_irq_flag
  ) else $error("Compare flag set in PWM.");

  AST_IRQ_SET: assert property ( // [RULE17]
    is_simple(compare_mode_field) && match_primary |=> compare_irq_flag
  ) else $error("Compare event did not set the flag.");

  AST_SLEEP_HOLD: assert property ( // [RULE19]
    cpu_sleep |=> $stable(compare_output_pin) &&
    $stable(compare_output_pin_oe_n)
  ) else $error("Pin changed during sleep.");

endmodule

`default_nettype wire

// ==== dv/occ_pin_load.sv ====
// Load model on the compare pin: resolves the pad from drive and enable.
`timescale 1ns/1ps
`default_nettype none

module occ_pin_load #(
  parameter logic PULL_LEVEL = 1'b1
) (
  input wire logic compare_output_pin,
  input wire logic compare_output_pin_oe_n,
  output logic pad
);
  // ****************************************************************
  // Pad level
  // ****************************************************************
  // A released pad shows the pull level, so a stale driven value hides
  // a missed tri-state only when it equals that level.
  assign pad = compare_output_pin_oe_n ? PULL_LEVEL :
    compare_output_pin;
endmodule

`default_nettype wire

// ==== dv/output_compare_pwm_channel_tb_top.sv ====
// Self-checking bench for the output compare and PWM channel.
`timescale 1ns/1ps
`default_nettype none

module output_compare_pwm_channel_tb_top;
  logic clk_sys, reset, reg_wr, reg_rd, cpu_sleep, cpu_idle, fault_n;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic pin, oe_n, irq, pad;
  logic [15:0] t_cnt [2];
  logic [15:0] t_per [2];
  logic t_run [2];
  logic t_stp [2];
  logic t_sidl;
  occ_pkg::occ_timer_t timer_a, timer_b;
  int failures, comparisons;

  occ_channel uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_a(timer_a), .timer_b(timer_b),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
    .fault_input_pin_n(fault_n), .compare_output_pin(pin),
    .compare_output_pin_oe_n(oe_n), .compare_irq_flag(irq));
  occ_pin_load load (.compare_output_pin(pin),
    .compare_output_pin_oe_n(oe_n), .pad(pad));

  // ****************************************************************
  // Timers: one step per clock while running outside sleep, cleared while stopped
  // ****************************************************************
  assign timer_a = '{count: t_cnt[0], period: t_per[0], step: t_stp[0],
    run: t_run[0], idle_stop: t_sidl};
  assign timer_b = '{count: t_cnt[1], period: t_per[1], step: t_stp[1],
    run: t_run[1], idle_stop: 1'b0};

  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      t_stp[i] <= t_run[i] && !cpu_sleep;
      if (!t_run[i])
        t_cnt[i] <= 16'h0000;
      else if (!cpu_sleep)
        t_cnt[i] <= (t_cnt[i] == t_per[i]) ? 16'h0000 : t_cnt[i] + 16'h0001;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata);
  endtask

  // Waits a bounded number of cycles for the pin (sel 0) or enable (sel 1).
  task automatic wait_for(input logic sel, input logic exp, input int n);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge clk_sys);
      #1;
      seen = ((sel ? oe_n : pin) === exp);
    end
    check(sel ? "oe_n_wait" : "pin_wait", 16'h0001, {15'h0000, seen});
  endtask

  task automatic hold(input logic sel, input logic exp, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if ((sel ? oe_n : pin) !== exp)
        bad = 1'b1;
    end
    check(sel ? "oe_n_hold" : "pin_hold", 16'h0000, {15'h0000, bad});
  endtask

  // Loads a duty value, lets it latch, then counts high cycles over one
  // ten-cycle period.
  task automatic duty(input logic [15:0] d, input int exp);
    int h;
    h = 0;
    wr(occ_pkg::OFS_SECONDARY, d);
    repeat (25) @(posedge clk_sys);
    repeat (10) begin
      @(posedge clk_sys);
      #1;
      h += (pin === 1'b1);
    end
    check("pwm_high_cycles", exp[15:0], h[15:0]);
  endtask

  task automatic finish_test();
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    cpu_sleep = 1'b0;
    cpu_idle = 1'b0;
    fault_n = 1'b1;
    t_sidl = 1'b0;
    failures = 0;
    comparisons = 0;
    t_run = '{1'b0, 1'b0};
    t_per = '{16'h0009, 16'h0009};
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(occ_pkg::OFS_CONTROL, 16'h0000);
    rd(occ_pkg::OFS_PRIMARY, 16'h0000);
    rd(occ_pkg::OFS_SECONDARY, 16'h0000);
    rd(16'h0186, 16'h0000);
    check("pad_released", 16'h0001, {15'h0000, pad});
    wr(occ_pkg::OFS_PRIMARY, 16'h0005);
    t_run[0] <= 1'b1;
    wr(occ_pkg::OFS_CONTROL, 16'h0002);
    wait_for(1'b0, 1'b1, 12);
    t_run[0] <= 1'b0;
    rd(occ_pkg::OFS_STATUS, 16'h0003);
    wr(occ_pkg::OFS_STATUS, 16'h0001);
    rd(occ_pkg::OFS_STATUS, 16'h0002);
    t_run[0] <= 1'b1;
    wr(occ_pkg::OFS_CONTROL, 16'h0003);
    wait_for(1'b0, 1'b0, 12);
    wait_for(1'b0, 1'b1, 12);
    wr(occ_pkg::OFS_CONTROL, 16'h0001);
    wait_for(1'b0, 1'b0, 12);
    wr(occ_pkg::OFS_PRIMARY, 16'h0014);
    wr(occ_pkg::OFS_CONTROL, 16'h0003);
    hold(1'b0, 1'b0, 30);
    wr(occ_pkg::OFS_PRIMARY, 16'h0005);
    wr(occ_pkg::OFS_CONTROL, 16'h000B);
    hold(1'b0, 1'b0, 25);
    t_run[1] <= 1'b1;
    wait_for(1'b0, 1'b1, 12);
    t_run[1] <= 1'b0;
    cpu_idle <= 1'b1;
    wr(occ_pkg::OFS_CONTROL, 16'h2003);
    hold(1'b0, 1'b1, 25);
    t_sidl <= 1'b1;
    wr(occ_pkg::OFS_CONTROL, 16'h0003);
    hold(1'b0, 1'b1, 25);
    t_sidl <= 1'b0;
    wait_for(1'b0, 1'b0, 12);
    cpu_idle <= 1'b0;
    t_run[0] <= 1'b0;
    wr(occ_pkg::OFS_CONTROL, 16'h0001);
    wr(occ_pkg::OFS_PRIMARY, 16'h0003);
    wr(occ_pkg::OFS_SECONDARY, 16'h0006);
    wr(occ_pkg::OFS_CONTROL, 16'h0004);
    t_run[0] <= 1'b1;
    wait_for(1'b0, 1'b1, 12);
    wait_for(1'b0, 1'b0, 12);
    hold(1'b0, 1'b0, 30);
    wr(occ_pkg::OFS_CONTROL, 16'h0004);
    wait_for(1'b0, 1'b1, 12);
    wr(occ_pkg::OFS_CONTROL, 16'h0005);
    repeat (2) begin
      wait_for(1'b0, 1'b0, 12);
      wait_for(1'b0, 1'b1, 12);
    end
    t_run[0] <= 1'b0;
    wr(occ_pkg::OFS_STATUS, 16'h0001);
    wr(occ_pkg::OFS_SECONDARY, 16'h0004);
    wr(occ_pkg::OFS_CONTROL, 16'h0006);
    wr(occ_pkg::OFS_PRIMARY, 16'h0007);
    t_run[0] <= 1'b1;
    wait_for(1'b0, 1'b1, 12);
    wait_for(1'b0, 1'b0, 12);
    wait_for(1'b0, 1'b1, 12);
    rd(occ_pkg::OFS_PRIMARY, 16'h0004);
    duty(16'h0000, 0);
    duty(16'h000C, 10);
    duty(16'h0004, 4);
    check("irq_in_pwm", 16'h0000, {15'h0000, irq});
    wait_for(1'b0, 1'b1, 12);
    cpu_sleep <= 1'b1;
    hold(1'b0, 1'b1, 30);
    cpu_sleep <= 1'b0;
    wait_for(1'b0, 1'b0, 12);
    wr(occ_pkg::OFS_CONTROL, 16'h0007);
    wait_for(1'b1, 1'b0, 12);
    fault_n <= 1'b0;
    wait_for(1'b1, 1'b1, 8);
    check("pad_fault", 16'h0001, {15'h0000, pad});
    rd(occ_pkg::OFS_CONTROL, 16'h0017);
    fault_n <= 1'b1;
    hold(1'b1, 1'b1, 20);
    wr(occ_pkg::OFS_CONTROL, 16'h0007);
    wait_for(1'b1, 1'b0, 15);
    rd(occ_pkg::OFS_CONTROL, 16'h0007);
    finish_test();
  end
endmodule

`default_nettype wire
